// ---- rtl/rsl_strap_latch.sv ----
// Strap latch top: pin turnaround, decoded configuration and APB registers.
// Notes on behaviour
// - Every strap pin is sampled at reset release and held afterwards.
// - Three address straps form a PHY management address from 0 to 7.
// - Receive data 3, 2, 1 supply address bits 0, 1, 2.
// - Negotiation strap high disables; stored inverted into the control bit.
// - Low test-chain strap at release enables test mode; high leaves it off.
// - High filter strap at release disables emission filtering; low keeps it.
// - Shared pins are pulled inputs during reset, then drive their normal outputs.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsl_defs.svh"
module rsl_strap_latch
  import rsl_pkg::*;
#(
  parameter int PADDR_W = 12
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PADDR_W-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [`RSL_PIN_W-1:0] strap_pin_i,
  output logic [`RSL_PIN_W-1:0]      strap_pin_o,
  output logic [`RSL_PIN_W-1:0]      strap_pin_oe,
  output logic [`RSL_PIN_W-1:0]      strap_pull_en,
  output logic [`RSL_PIN_W-1:0]      strap_pull_up,
  input  wire logic [`RSL_PIN_W-1:0] func_out,
  output logic [2:0]                 phy_addr_strap,
  output logic                       mode_normal,
  output logic                       mode_b2b,
  output logic                       auto_mdix_en,
  output logic                       mode_reserved,
  output logic                       aneg_en,
  output logic                       nand_tree_en,
  output logic                       emi_filter_off_strap,
  output logic                       cfg_valid
);

  if (PADDR_W < 3 || PADDR_W > 32)
  begin : g_bad_width
    $error("PADDR_W must lie between 3 and 32.");
  end

  function automatic rsl_mode_t decode_mode(input logic [2:0] code);
    rsl_mode_t m;
    m = '{normal: 1'b0, b2b: 1'b0, mdix: 1'b0, rsvd: 1'b0};
    if (code == `RSL_MODE_NORMAL)
      m.normal = 1'b1;
    else if (code == `RSL_MODE_NORM_MDIX)
    begin
      m.normal = 1'b1;
      m.mdix   = 1'b1;
    end
    else if (code == `RSL_MODE_B2B_MDIX)
    begin
      m.b2b  = 1'b1;
      m.mdix = 1'b1;
    end
    else
      m.rsvd = 1'b1;
    return m;
  endfunction

  function automatic logic addr_hit(input logic [PADDR_W-1:0] a, input logic [11:0] ofs);
    return a == PADDR_W'(ofs);
  endfunction

  rsl_cfg_if cfg ();

  rsl_sampler u_sampler
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_i   (strap_pin_i),
    .cfg     (cfg.src)
  );

  // Configuration outputs and pin turnaround.
  rsl_mode_t             mode_d;
  logic [`RSL_PIN_W-1:0] oe_q;
  logic [`RSL_PIN_W-1:0] oe_d;
  logic [`RSL_PIN_W-1:0] pout_q;
  logic [`RSL_PIN_W-1:0] pout_d;
  logic [`RSL_PIN_W-1:0] pull_en_q;
  logic [`RSL_PIN_W-1:0] pull_en_d;
  logic [2:0]            addr_q;
  logic [2:0]            code_q;
  rsl_mode_t             mode_q;
  logic                  nand_q;
  logic                  emi_q;
  logic                  sa_q;
  logic                  valid_q;
  logic                  aneg_q;
  logic                  aneg_d;

  always_comb
  begin
    mode_d    = decode_mode(cfg.mode_code);
    // Pins stay released until the capture is done so the board pulls set the level.
    oe_d      = cfg.done ? {`RSL_PIN_W{1'b1}} : {`RSL_PIN_W{1'b0}};
    pull_en_d = cfg.done ? {`RSL_PIN_W{1'b0}} : {`RSL_PIN_W{1'b1}};
    pout_d    = cfg.done ? func_out : {`RSL_PIN_W{1'b0}};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oe_q      <= {`RSL_PIN_W{1'b0}};
      pout_q    <= {`RSL_PIN_W{1'b0}};
      pull_en_q <= {`RSL_PIN_W{1'b1}};
      addr_q    <= 3'h0;
      code_q    <= 3'h0;
      mode_q    <= '{normal: 1'b0, b2b: 1'b0, mdix: 1'b0, rsvd: 1'b0};
      nand_q    <= 1'b0;
      emi_q     <= 1'b0;
      sa_q      <= 1'b1;
      valid_q   <= 1'b0;
    end
    else
    begin
      oe_q      <= oe_d;
      pout_q    <= pout_d;
      pull_en_q <= pull_en_d;
      addr_q    <= cfg.phy_addr;
      code_q    <= cfg.mode_code;
      mode_q    <= cfg.done ? mode_d : mode_q;
      nand_q    <= cfg.done & ~cfg.nand_n;
      emi_q     <= cfg.done & cfg.emi_off;
      sa_q      <= cfg.strap_a;
      valid_q   <= cfg.done;
    end
  end

  // APB slave: the answer comes one cycle into the access phase.
  logic        rdy_q;
  logic        rdy_d;
  logic        err_q;
  logic        err_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] status_w;
  logic        hit_st;
  logic        hit_ctrl;
  logic        wr_fire;
  logic        cap_edge;
  logic        done_q;

  always_comb
  begin
    status_w = 32'h0;
    status_w[`RSL_ST_ADDR_LSB +: 3] = addr_q;
    status_w[`RSL_ST_MODE_LSB +: 3] = code_q;
    status_w[`RSL_ST_NORMAL]        = mode_q.normal;
    status_w[`RSL_ST_B2B]           = mode_q.b2b;
    status_w[`RSL_ST_MDIX]          = mode_q.mdix;
    status_w[`RSL_ST_RSVD]          = mode_q.rsvd;
    status_w[`RSL_ST_NAND]          = nand_q;
    status_w[`RSL_ST_EMI_OFF]       = emi_q;
    status_w[`RSL_ST_STRAP_A]       = sa_q;
    status_w[`RSL_ST_VALID]         = valid_q;
    hit_st   = addr_hit(paddr, `RSL_OFS_STATUS);
    hit_ctrl = addr_hit(paddr, `RSL_OFS_CTRL);
    rdy_d    = psel & penable & ~rdy_q;
    err_d    = rdy_d & ~hit_st & ~hit_ctrl;
    rdata_d  = 32'h0;
    if (rdy_d && !pwrite && hit_st)
      rdata_d = status_w;
    else if (rdy_d && !pwrite && hit_ctrl)
      rdata_d[`RSL_CTRL_ANEG_EN] = aneg_q;
    wr_fire  = psel & penable & rdy_q & pwrite & hit_ctrl & pstrb[0];
    cap_edge = cfg.done & ~done_q;
    // The one-time load from the strap outranks a write landing on the same edge.
    if (cap_edge)
      aneg_d = ~cfg.strap_a;
    else if (wr_fire)
      aneg_d = pwdata[`RSL_CTRL_ANEG_EN];
    else
      aneg_d = aneg_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0;
      aneg_q  <= 1'(`RSL_CTRL_RESET);
      done_q  <= 1'b0;
    end
    else
    begin
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
      aneg_q  <= aneg_d;
      done_q  <= cfg.done;
    end
  end

  assign prdata               = rdata_q;
  assign pready               = rdy_q;
  assign pslverr              = err_q;
  assign strap_pin_o          = pout_q;
  assign strap_pin_oe         = oe_q;
  assign strap_pull_en        = pull_en_q;
  assign strap_pull_up        = `RSL_PULL_UP_MASK;
  assign phy_addr_strap       = addr_q;
  assign mode_normal          = mode_q.normal;
  assign mode_b2b             = mode_q.b2b;
  assign auto_mdix_en         = mode_q.mdix;
  assign mode_reserved        = mode_q.rsvd;
  assign aneg_en              = aneg_q;
  assign nand_tree_en         = nand_q;
  assign emi_filter_off_strap = emi_q;
  assign cfg_valid            = valid_q;
endmodule // rsl_strap_latch
`default_nettype wire

// ---- rtl/rsl_defs.svh ----
// Offsets, pin positions, field positions, reset values and counts for the strap latch.
`ifndef RSL_DEFS_SVH
`define RSL_DEFS_SVH

`define RSL_PIN_W          9
`define RSL_PIN_RXD0       0
`define RSL_PIN_RXD1       1
`define RSL_PIN_RXD2       2
`define RSL_PIN_RXD3       3
`define RSL_PIN_RXDV       4
`define RSL_PIN_CRS        5
`define RSL_PIN_RXC        6
`define RSL_PIN_RXER       7
`define RSL_PIN_INTR       8
`define RSL_PULL_UP_MASK   9'h109
`define RSL_SYNC_STAGES    2

`define RSL_OFS_STATUS     12'h000
`define RSL_OFS_CTRL       12'h004

`define RSL_ST_ADDR_LSB    0
`define RSL_ST_MODE_LSB    3
`define RSL_ST_NORMAL      6
`define RSL_ST_B2B         7
`define RSL_ST_MDIX        8
`define RSL_ST_RSVD        9
`define RSL_ST_NAND        10
`define RSL_ST_EMI_OFF     11
`define RSL_ST_STRAP_A     12
`define RSL_ST_VALID       13
`define RSL_CTRL_ANEG_EN   0
`define RSL_CTRL_RESET     32'h0000_0000

`define RSL_MODE_NORMAL    3'h0
`define RSL_MODE_NORM_MDIX 3'h2
`define RSL_MODE_B2B_MDIX  3'h6

`endif

// ---- rtl/rsl_pkg.sv ----
// Types shared by the strap latch modules.
package rsl_pkg;

  typedef enum logic [2:0]
  {
    RSL_ST_WAIT = 3'b001,
    RSL_ST_CAPT = 3'b010,
    RSL_ST_RUN  = 3'b100
  } rsl_state_t;

  typedef struct packed
  {
    logic normal;
    logic b2b;
    logic mdix;
    logic rsvd;
  } rsl_mode_t;

endpackage

// ---- rtl/rsl_cfg_if.sv ----
// Captured strap values passed from the sampler to the top module.
`timescale 1ns/1ps
`default_nettype none
interface rsl_cfg_if;
  logic       done;
  logic [2:0] phy_addr;
  logic [2:0] mode_code;
  logic       strap_a;
  logic       nand_n;
  logic       emi_off;

  modport src (output done, output phy_addr, output mode_code, output strap_a, output nand_n,
               output emi_off);
  modport dst (input done, input phy_addr, input mode_code, input strap_a, input nand_n,
               input emi_off);
endinterface
`default_nettype wire

// ---- rtl/rsl_sampler.sv ----
// Synchronises the strap pins and captures them once after reset release.
`timescale 1ns/1ps
`default_nettype none
`include "rsl_defs.svh"
module rsl_sampler
  import rsl_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [`RSL_PIN_W-1:0] pin_i,
  rsl_cfg_if.src                     cfg
);
  logic [`RSL_PIN_W-1:0] sync1_q;
  logic [`RSL_PIN_W-1:0] sync2_q;
  rsl_state_t            state_q;
  rsl_state_t            state_d;
  logic [`RSL_PIN_W-1:0] cap_q;
  logic [`RSL_PIN_W-1:0] cap_d;
  logic                  armed_q;
  logic                  armed_d;

  // The first stage of the pipeline is read only by the second stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= `RSL_PULL_UP_MASK;
      sync2_q <= `RSL_PULL_UP_MASK;
    end
    else
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // The level seen at the first edge after release needs two edges to leave the second
  // stage, so WAIT lasts two cycles; pins stay undriven inputs until RUN.
  always_comb
  begin
    state_d = state_q;
    cap_d   = cap_q;
    armed_d = 1'b1;
    case (state_q)
      RSL_ST_WAIT: state_d = armed_q ? RSL_ST_CAPT : RSL_ST_WAIT;
      RSL_ST_CAPT:
      begin
        cap_d   = sync2_q;
        state_d = RSL_ST_RUN;
      end
      RSL_ST_RUN:  state_d = RSL_ST_RUN;
      default:     state_d = RSL_ST_WAIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= RSL_ST_WAIT;
      cap_q   <= `RSL_PULL_UP_MASK;
      armed_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cap_q   <= cap_d;
      armed_q <= armed_d;
    end
  end

  assign cfg.done      = (state_q == RSL_ST_RUN);
  assign cfg.phy_addr  = {cap_q[`RSL_PIN_RXD1], cap_q[`RSL_PIN_RXD2],
                          cap_q[`RSL_PIN_RXD3]};
  assign cfg.mode_code = {cap_q[`RSL_PIN_RXDV], cap_q[`RSL_PIN_CRS], cap_q[`RSL_PIN_RXC]};
  assign cfg.strap_a   = cap_q[`RSL_PIN_RXD0];
  assign cfg.nand_n    = cap_q[`RSL_PIN_INTR];
  assign cfg.emi_off   = cap_q[`RSL_PIN_RXER];
endmodule // rsl_sampler
`default_nettype wire

// ---- test/rsl_strap_latch_checker.sv ----
// Port assertions for the strap latch.
`timescale 1ns/1ps
`default_nettype none
module rsl_strap_latch_checker
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [8:0] strap_pin_i,
  input wire logic [8:0] strap_pin_o,
  input wire logic [8:0] strap_pin_oe,
  input wire logic [8:0] strap_pull_en,
  input wire logic [8:0] func_out,
  input wire logic [2:0] phy_addr_strap,
  input wire logic       mode_normal,
  input wire logic       mode_b2b,
  input wire logic       auto_mdix_en,
  input wire logic       mode_reserved,
  input wire logic       aneg_en,
  input wire logic       nand_tree_en,
  input wire logic       emi_filter_off_strap,
  input wire logic       cfg_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic [3:0] mdec(input logic [2:0] c);
    case (c)
      3'h0: return 4'b1000;
      3'h2: return 4'b1010;
      3'h6: return 4'b0110;
      default: return 4'b0001;
    endcase
  endfunction
  property p_addr;
    $rose(cfg_valid) |-> phy_addr_strap ==
      {$past(strap_pin_i[1], 4), $past(strap_pin_i[2], 4), $past(strap_pin_i[3], 4)};
  endproperty
  a_addr: assert property (p_addr) else $error("address strap wrong");
  property p_mode;
    $rose(cfg_valid) |-> {mode_normal, mode_b2b, auto_mdix_en, mode_reserved} ==
      mdec({$past(strap_pin_i[4], 4), $past(strap_pin_i[5], 4), $past(strap_pin_i[6], 4)});
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_aneg;
    $rose(cfg_valid) |-> aneg_en == !$past(strap_pin_i[0], 4);
  endproperty
  a_aneg: assert property (p_aneg) else $error("negotiation bit wrong");
  property p_test;
    $rose(cfg_valid) |-> nand_tree_en == !$past(strap_pin_i[8], 4);
  endproperty
  a_test: assert property (p_test) else $error("test chain wrong");
  property p_emi;
    $rose(cfg_valid) |-> emi_filter_off_strap == $past(strap_pin_i[7], 4);
  endproperty
  a_emi: assert property (p_emi) else $error("filter strap wrong");
  property p_hold;
    cfg_valid && $past(cfg_valid) |-> cfg_valid && $stable(phy_addr_strap) &&
      $stable({mode_normal, mode_b2b, auto_mdix_en, nand_tree_en, emi_filter_off_strap});
  endproperty
  a_hold: assert property (p_hold) else $error("captured value moved");
  property p_turn;
    strap_pin_oe == {9{cfg_valid}} && (strap_pin_oe & strap_pull_en) == 9'h000;
  endproperty
  a_turn: assert property (p_turn) else $error("pin direction wrong");
  property p_drive;
    cfg_valid && $past(cfg_valid) |-> strap_pin_o == $past(func_out);
  endproperty
  a_drive: assert property (p_drive) else $error("pin output wrong");
endmodule // rsl_strap_latch_checker
`default_nettype wire

// ---- test/rsl_board_model.sv ----
// Board strap resistors and the attached receiver, resolving each shared pin.
`timescale 1ns/1ps
`default_nettype none
module rsl_board_model
(
  input  wire logic       pclk,
  input  wire logic [8:0] pin_oe,
  input  wire logic [8:0] pin_o,
  input  wire logic [8:0] pull_en,
  input  wire logic [8:0] pull_up,
  input  wire logic [8:0] res_fit,
  input  wire logic [8:0] res_val,
  output logic [8:0]      level
);
  logic [8:0] float_q = 9'h0aa;
  always @(posedge pclk) float_q <= ~float_q;
  // The receiver never drives in reset; fitted resistors beat the weak pulls.
  // A line nobody holds toggles, so a stale value cannot pass for a strap.
  assign level = pin_oe & pin_o | ~pin_oe & (res_fit & res_val |
                 ~res_fit & (pull_en & pull_up | ~pull_en & float_q));
endmodule // rsl_board_model
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the strap latch.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb;
  import rsl_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [3:0]  strb = 4'hf;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [8:0]  fit = 0, val = 0, func_out = 0, p, level;
  logic [8:0]  strap_pin_o, strap_pin_oe, strap_pull_en, strap_pull_up;
  logic [2:0]  phy_addr_strap, c;
  logic        pready, pslverr, mode_normal, mode_b2b, auto_mdix_en, mode_reserved;
  logic        aneg_en, nand_tree_en, emi_filter_off_strap, cfg_valid;
  int          checks = 0, n_fail = 0, i;
  always #10 pclk = ~pclk;
  rsl_strap_latch u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(strb), .prdata, .pready, .pslverr, .strap_pin_i(level), .strap_pin_o,
    .strap_pin_oe, .strap_pull_en, .strap_pull_up, .func_out, .phy_addr_strap,
    .mode_normal, .mode_b2b, .auto_mdix_en, .mode_reserved, .aneg_en, .nand_tree_en,
    .emi_filter_off_strap, .cfg_valid);
  rsl_board_model u_board (.pclk, .pin_oe(strap_pin_oe), .pin_o(strap_pin_o),
    .pull_en(strap_pull_en), .pull_up(strap_pull_up), .res_fit(fit), .res_val(val), .level);
  task results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task bound(input int n);
    if (n >= 16)
    begin
      n_fail++;
      results();
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    bound(n);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task boot;
    int n;
    @(posedge pclk);
    presetn <= 0;
    repeat (12) @(posedge pclk);
    `CHK(strap_pin_oe, 9'h000)
    `CHK(strap_pull_en, 9'h1ff)
    presetn <= 1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (cfg_valid === 1'b1)
        break;
    end
    bound(n);
  endtask
  function automatic logic [31:0] exp_st(input logic [8:0] q);
    logic [3:0] m;
    case ({q[4], q[5], q[6]})
      3'h0: m = 4'b1000;
      3'h2: m = 4'b1010;
      3'h6: m = 4'b0110;
      default: m = 4'b0001;
    endcase
    return {18'h0, 1'b1, q[0], q[7], ~q[8], m[0], m[1], m[2], m[3], q[4], q[5], q[6],
            q[1], q[2], q[3]};
  endfunction
  initial
  begin
    // Eight fitted strap sets walk every mode code; the last relies on the weak pulls.
    for (i = 0; i < 9; i++)
    begin
      c = i[2:0];
      p = (i < 8) ? {c[0], c[1], c[0], c[1], c[2], ~c[0], ~c[1], ~c[2], c[2]} : 9'h109;
      fit <= (i < 8) ? 9'h1ff : 9'h000;
      val <= p;
      boot();
      apb(0, 12'h000, 32'h0);
      `CHK(rd, exp_st(p))
      apb(0, 12'h004, 32'h0);
      `CHK(rd, {31'h0, ~p[0]})
      val <= ~p;
      func_out <= ~p;
      repeat (4) @(posedge pclk);
      `CHK(level, ~p)
      apb(0, 12'h000, 32'h0);
      `CHK(rd, exp_st(p))
      $display("strap set %0d done", i);
    end
    apb(0, 12'h008, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    apb(1, 12'h004, 32'h1);
    apb(0, 12'h004, 32'h0);
    `CHK(rd, 32'h1)
    `CHK(aneg_en, 1'b1)
    strb <= 4'he;
    apb(1, 12'h004, 32'h0);
    strb <= 4'hf;
    apb(1, 12'h000, 32'hffff_ffff);
    apb(0, 12'h004, 32'h0);
    `CHK({err, rd}, 33'h000000001)
    apb(0, 12'h000, 32'h0);
    `CHK(rd, exp_st(9'h109))
    `CHK(strap_pull_up, 9'h109)
    func_out <= 9'h0a5;
    repeat (3) @(posedge pclk);
    `CHK(level, 9'h0a5)
    $display("bus and pin drive test done");
    results();
  end
endmodule // tb
bind rsl_strap_latch rsl_strap_latch_checker u_chk (.pclk, .presetn, .strap_pin_i,
  .strap_pin_o, .strap_pin_oe, .strap_pull_en, .func_out, .phy_addr_strap, .mode_normal,
  .mode_b2b, .auto_mdix_en, .mode_reserved, .aneg_en, .nand_tree_en,
  .emi_filter_off_strap, .cfg_valid);
`default_nettype wire
